// ---- ddr3_timing_regs.vh ----
// named constants for the DDR3 command-timing core
// assumes the core clock runs at 50 MHz and the memory clock is sampled by it
`ifndef DDR3_TIMING_REGS_VH
`define DDR3_TIMING_REGS_VH

// core clock period and derived refresh busy time
`define CLK_PERIOD_NS              20
`define REFRESH_CYCLE_TIME_NS      260
`define REFRESH_CYCLE_CLKS         ((`REFRESH_CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// refresh interval limits, in ns, for reference by the controller side
`define REFRESH_AVERAGE_INTERVAL_NORMAL_NS 7800
`define REFRESH_AVERAGE_INTERVAL_HOT_NS    3900

// write-leveling waits in memory clocks, kept by the controller side
`define LEVELING_STROBE_ENABLE_DELAY 25
`define LEVELING_FIRST_STROBE_DELAY  40

// memory-clock cycle counts, then burst beat counts and the upper-nibble start beat
`define TERM_HIGH_TIME_WRITE_EIGHT 3'h6
`define TERM_ON_LATENCY_OFFSET     5'h02
`define WRITE_START_OFFSET_EIGHT   5'h04
`define WRITE_START_OFFSET_CHOP    5'h02
`define SHORT_CAL_CK               7'h40
`define BEATS_EIGHT                4'h8
`define BEATS_CHOP                 4'h4
`define NIBBLE_UPPER_START         3'h4

// command codes on the command pins
`define CMD_NOP  3'h0
`define CMD_ACT  3'h1
`define CMD_PRE  3'h2
`define CMD_RD   3'h3
`define CMD_WR   3'h4
`define CMD_REF  3'h5
`define CMD_SHORT_IMPEDANCE_CALIBRATION 3'h6
`define CMD_MRS  3'h7

// calibration readout pattern levels on the data pins
`define READOUT_LOW  8'h00
`define READOUT_HIGH 8'hFF

`endif

// ---- sync_2ff.v ----
// two-stage synchroniser for a bus of independent levels
// assumes each bit is a slow level or is only used after edge finding
`timescale 1ns/1ps
module sync_2ff #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// ---- ddr3_timing_core.v ----
// DDR3 device-side command timing: write start, termination latency,
// refresh/row/calibration busy, power-down entry and calibration readout.
// assumes all pins are asynchronous to clk_i and the memory clock is slow
// enough (at least four core cycles per phase) to be sampled by clk_i.
`timescale 1ns/1ps
`include "ddr3_timing_regs.vh"
module ddr3_timing_core #(
  parameter PIPE_W      = 32,
  parameter ROW_BUSY_CK = 11
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       ck_i,
  input  wire       cke_i,
  input  wire [2:0] cmd_i,
  input  wire       on_die_termination_control_i,
  input  wire       burst_chop_four_i,
  input  wire       auto_precharge_i,
  input  wire       nibble_select_i,
  input  wire [3:0] write_latency_setting_i,
  input  wire [3:0] additive_latency_i,
  input  wire [3:0] read_latency_setting_i,
  input  wire       chop_fixed_i,
  input  wire       readout_enable_i,
  output wire       write_start_o,
  output wire       term_enable_o,
  output wire       busy_o,
  output wire       calibration_busy_o,
  output wire       powerdown_o,
  output wire [7:0] dq_o,
  output wire       dq_oe_o,
  output wire       term_short_o,
  output wire       refresh_early_o
);
  localparam SYNC_W = 23;
  localparam integer REF_BUSY_RAW = `REFRESH_CYCLE_CLKS;

  // one-hot tap for a delay of d memory-clock rises
  function [PIPE_W-1:0] tap;
    input [4:0] d;
    begin
      if (d == 5'h00)
        tap = {PIPE_W{1'b0}};
      else
        tap = {{(PIPE_W-1){1'b0}}, 1'b1} << (d - 5'h01);
    end
  endfunction

  wire [SYNC_W-1:0] sync_w;
  wire              ck_s;
  wire              cke_s;
  wire [2:0]        cmd_s;
  wire              odt_s;
  wire              chop_s;
  wire              ap_s;
  wire              a2_s;
  wire [3:0]        cwl_s;
  wire [3:0]        al_s;
  wire [3:0]        cl_s;
  wire              chop_fixed_s;
  wire              ro_en_s;

  sync_2ff #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({readout_enable_i, chop_fixed_i, read_latency_setting_i,
                additive_latency_i, write_latency_setting_i, nibble_select_i,
                auto_precharge_i, burst_chop_four_i, on_die_termination_control_i,
                cmd_i, cke_i, ck_i}),
    .q_o      (sync_w)
  );

  assign {ro_en_s, chop_fixed_s, cl_s, al_s, cwl_s, a2_s, ap_s, chop_s,
          odt_s, cmd_s, cke_s, ck_s} = sync_w;

  reg ck_prev_q;
  // memory-clock edges found on the synchronised copy; no timeout anywhere
  wire ck_rise = ck_s & ~ck_prev_q;
  wire ck_fall = ~ck_s & ck_prev_q;
  wire cmd_ok  = ck_rise & cke_s;

  // latency sums
  wire [4:0] wl       = {1'b0, cwl_s} + {1'b0, al_s};
  wire [4:0] rl       = {1'b0, cl_s} + {1'b0, al_s};
  wire [4:0] wr_delay = wl + (chop_fixed_s ? `WRITE_START_OFFSET_CHOP
                                           : `WRITE_START_OFFSET_EIGHT);
  wire [4:0] term_lat = (wl > `TERM_ON_LATENCY_OFFSET) ?
                        (wl - `TERM_ON_LATENCY_OFFSET) : 5'h00;

  reg [PIPE_W-1:0] wr_pend_q;
  reg [PIPE_W-1:0] rd_pend_q;
  reg [PIPE_W-1:0] term_hist_q;
  reg              write_start_q;
  reg              term_on_q;
  reg [2:0]        odt_cnt_q;
  reg              term_short_q;
  reg [4:0]        ref_cnt_q;
  reg              refresh_early_q;
  reg [7:0]        row_cnt_q;
  reg [6:0]        zq_cnt_q;
  reg              pd_req_q;
  reg              powerdown_q;
  reg [3:0]        beats_left_q;
  reg [2:0]        beat_q;
  reg              rd_nib_q;
  reg              rd_chop_q;
  reg [7:0]        dq_q;
  reg              dq_oe_q;

  wire is_wr   = cmd_ok & (cmd_s == `CMD_WR);
  wire is_rd   = cmd_ok & (cmd_s == `CMD_RD);
  wire is_ref  = cmd_ok & (cmd_s == `CMD_REF);
  wire is_act  = cmd_ok & (cmd_s == `CMD_ACT);
  wire is_pre  = cmd_ok & (cmd_s == `CMD_PRE);
  wire is_zq   = cmd_ok & (cmd_s == `CMD_SHORT_IMPEDANCE_CALIBRATION);
  wire row_op  = is_act | is_pre | ((is_rd | is_wr) & ap_s);
  wire busy    = (ref_cnt_q != 5'h00) | (row_cnt_q != 8'h00) | (zq_cnt_q != 7'h00);

  // write start and read latency pipelines, shifted on each rising clock edge
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ck_prev_q     <= 1'b0;
      wr_pend_q     <= {PIPE_W{1'b0}};
      rd_pend_q     <= {PIPE_W{1'b0}};
      write_start_q <= 1'b0;
    end
    else
    begin
      ck_prev_q     <= ck_s;
      write_start_q <= ck_rise & wr_pend_q[0];
      if (ck_rise)
      begin
        wr_pend_q <= (wr_pend_q >> 1) | (is_wr ? tap(wr_delay) : {PIPE_W{1'b0}});
        rd_pend_q <= (rd_pend_q >> 1) | (is_rd ? tap(rl) : {PIPE_W{1'b0}});
      end
    end
  end

  // termination follows its control delayed by write latency minus two
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      term_hist_q  <= {PIPE_W{1'b0}};
      term_on_q    <= 1'b0;
      odt_cnt_q    <= 3'h0;
      term_short_q <= 1'b0;
    end
    else
    begin
      if (ck_rise)
        term_hist_q <= {term_hist_q[PIPE_W-2:0], odt_s};
      term_on_q <= term_hist_q[term_lat]; // bit n: sampled n rises before latest
      // flag termination dropped too early around an eight-beat write
      if (is_wr & ~chop_fixed_s & ~chop_s)
      begin
        odt_cnt_q <= `TERM_HIGH_TIME_WRITE_EIGHT - 3'h1;
        if (!odt_s)
          term_short_q <= 1'b1;
      end
      else if (ck_rise && odt_cnt_q != 3'h0)
      begin
        odt_cnt_q <= odt_cnt_q - 3'h1;
        if (!odt_s)
          term_short_q <= 1'b1;
      end
    end
  end

  // busy timers: refresh in core cycles, row and calibration in clock rises
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_cnt_q       <= 5'h00;
      refresh_early_q <= 1'b0;
      row_cnt_q       <= 8'h00;
      zq_cnt_q        <= 7'h00;
    end
    else
    begin
      if ((is_ref | is_act) && ref_cnt_q != 5'h00)
        refresh_early_q <= 1'b1;
      if (is_ref)
        ref_cnt_q <= REF_BUSY_RAW[4:0];
      else if (ref_cnt_q != 5'h00)
        ref_cnt_q <= ref_cnt_q - 5'h01;
      if (row_op)
        row_cnt_q <= ROW_BUSY_CK[7:0];
      else if (ck_rise && row_cnt_q != 8'h00)
        row_cnt_q <= row_cnt_q - 8'h01;
      if (is_zq)
        zq_cnt_q <= `SHORT_CAL_CK;
      else if (ck_rise && zq_cnt_q != 7'h00)
        zq_cnt_q <= zq_cnt_q - 7'h01;
    end
  end

  // clock enable low is taken at the next clock rise; low power waits for the refresh, row and calibration timers to clear
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pd_req_q    <= 1'b0;
      powerdown_q <= 1'b0;
    end
    else
    begin
      if (ck_rise)
        pd_req_q <= ~cke_s;
      powerdown_q <= pd_req_q & ~busy;
    end
  end

  // calibration readout burst, one beat per clock edge
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      beats_left_q <= 4'h0;
      beat_q       <= 3'h0;
      rd_nib_q     <= 1'b0;
      rd_chop_q    <= 1'b0;
      dq_q         <= `READOUT_LOW;
      dq_oe_q      <= 1'b0;
    end
    else
    begin
      if (is_rd)
      begin
        rd_nib_q  <= a2_s;
        rd_chop_q <= chop_fixed_s | chop_s;
      end
      if (ck_rise && rd_pend_q[0] && ro_en_s)
      begin
        beats_left_q <= (rd_chop_q ? `BEATS_CHOP : `BEATS_EIGHT) - 4'h1;
        beat_q       <= rd_nib_q ? `NIBBLE_UPPER_START : 3'h0;
        dq_q         <= `READOUT_LOW;
        dq_oe_q      <= 1'b1;
      end
      else if ((ck_rise | ck_fall) && dq_oe_q)
      begin
        if (beats_left_q == 4'h0)
        begin
          dq_oe_q <= 1'b0;
          dq_q    <= `READOUT_LOW;
        end
        else
        begin
          beats_left_q <= beats_left_q - 4'h1;
          beat_q       <= beat_q + 3'h1;
          // pattern bit is the low bit of the beat number
          dq_q <= beat_q[0] ? `READOUT_LOW : `READOUT_HIGH;
        end
      end
    end
  end

  assign write_start_o      = write_start_q;
  assign term_enable_o      = term_on_q;
  assign busy_o             = busy;
  assign calibration_busy_o = (zq_cnt_q != 7'h00);
  assign powerdown_o        = powerdown_q;
  assign dq_o               = dq_q;
  assign dq_oe_o            = dq_oe_q;
  assign term_short_o       = term_short_q;
  assign refresh_early_o    = refresh_early_q;
endmodule

// ---- ddr3_timing_core_monitor.sv ----
// checker for the timing core: busy, power-down, readout and write pulse
// assumes ck_i is slow against clk_i and bound onto the core's ports
`timescale 1ns/1ps
module ddr3_timing_core_monitor (
  input wire       clk_i,
  input wire       resetn_i,
  input wire       ck_i,
  input wire       on_die_termination_control_i,
  input wire       readout_enable_i,
  input wire       write_start_o,
  input wire       term_enable_o,
  input wire       busy_o,
  input wire       calibration_busy_o,
  input wire       powerdown_o,
  input wire [7:0] dq_o,
  input wire       dq_oe_o
);
  reg       ck_q;
  reg [7:0] rise_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // memory clock rises counted while calibration runs
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ck_q   <= 1'b0;
      rise_q <= 8'h00;
    end
    else
    begin
      ck_q   <= ck_i;
      rise_q <= !calibration_busy_o ? 8'h00 : rise_q + {7'h00, ck_i & ~ck_q};
    end
  end
  // power-down level only once no refresh, row or calibration timer runs
  chk_pd_after_idle: assert property (powerdown_o |-> !$past(busy_o))
    else $error("power-down reported while busy");
  chk_busy_min_len: assert property ($rose(busy_o) |-> busy_o[*8])
    else $error("busy shorter than eight cycles");
  chk_cal_in_busy: assert property (calibration_busy_o |-> busy_o)
    else $error("calibration running without busy");
  chk_cal_span: assert property ($fell(calibration_busy_o) |->
    rise_q >= 8'h3F && rise_q <= 8'h41)
    else $error("calibration span not 64 memory clocks");
  chk_write_on_rise: assert property (write_start_o |->
    $past(ck_i, 2) && !$past(write_start_o))
    else $error("write start not a single pulse after a clock rise");
  chk_dq_levels: assert property (dq_oe_o |-> dq_o == 8'h00 || dq_o == 8'hFF)
    else $error("readout data not a pattern level");
  chk_dq_first_beat: assert property ($rose(dq_oe_o) |->
    dq_o == 8'h00 && readout_enable_i)
    else $error("readout burst start wrong");
  chk_term_cause: assert property ($rose(term_enable_o) |->
    $past(on_die_termination_control_i, 16))
    else $error("termination on without earlier control");
endmodule
bind ddr3_timing_core ddr3_timing_core_monitor monitor_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .ck_i(ck_i),
  .on_die_termination_control_i(on_die_termination_control_i),
  .readout_enable_i(readout_enable_i), .write_start_o(write_start_o),
  .term_enable_o(term_enable_o), .busy_o(busy_o), .calibration_busy_o(calibration_busy_o),
  .powerdown_o(powerdown_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o)
);

// ---- ctl_model.sv ----
// controller model: free memory clock and one command per clock rise
// assumes clk_i runs eight times faster than the memory clock
`timescale 1ns/1ps
`include "ddr3_timing_regs.vh"
module ctl_model (
  input  wire       clk_i,
  output wire       ck_o,
  output reg  [2:0] cmd_o = 3'h0,
  output reg        chop_o = 1'b0,
  output reg        nib_o = 1'b0
);
  reg  [2:0] ph_q = 3'h0;
  reg        dll_locked = 1'b0;
  time       ref_t = 0;
  time       ref_gap = 0;
  localparam LOCK_CLKS = 64; // loop lock time, value arbitrary
  // memory clock of 160 ns, low in phases 0..3; slow enough for both latencies
  assign ck_o = ph_q[2];
  always @(posedge clk_i)
    ph_q <= ph_q + 3'h1;
  // delay-locked loop reports lock a fixed time after start
  initial
  begin
    repeat (LOCK_CLKS) @(posedge clk_i);
    dll_locked = 1'b1;
  end
  // command set at the start of the low phase, held across the rise, then back to idle
  task issue(input [2:0] c, input ch, input nb, input early);
  begin
    if (c == `CMD_REF || c == `CMD_ACT)
      while (!early && $time - ref_t < 260) @(posedge clk_i);
    while (c == `CMD_RD && !dll_locked) @(posedge clk_i);
    while (ph_q != 3'h0) @(posedge clk_i);
    cmd_o <= c;
    chop_o <= ch;
    nib_o <= nb;
    if (c == `CMD_REF)
    begin
      ref_gap = $time - ref_t;
      ref_t   = $time;
    end
    repeat (6) @(posedge clk_i);
    cmd_o <= `CMD_NOP;
  end
  endtask
  // write leveling after the mode set: strobe pair driven, then first strobe rise
  task level;
  begin
    repeat (`LEVELING_STROBE_ENABLE_DELAY) @(posedge ck_o);
    repeat (`LEVELING_FIRST_STROBE_DELAY - `LEVELING_STROBE_ENABLE_DELAY)
      @(posedge ck_o);
  end
  endtask
endmodule

// ---- ddr3_timing_core_tb.sv ----
// self-checking bench for the timing core
// assumes the controller model paces commands on the memory clock
`timescale 1ns/1ps
`include "ddr3_timing_regs.vh"
module ddr3_timing_core_tb;
  reg        clk_i = 1'b0;
  reg        resetn_i = 1'b0;
  reg        cke_i = 1'b1;
  reg        odt_q = 1'b0;
  reg        chop_fixed_q = 1'b0;
  reg        readout_q = 1'b0;
  reg        ap_q = 1'b0;
  wire       ck_i;
  wire [2:0] cmd_i;
  wire       chop_w, nib_w, write_start_o, term_enable_o, busy_o, calibration_busy_o;
  wire       powerdown_o, dq_oe_o, term_short_o, refresh_early_o;
  wire [7:0] dq_o;
  reg  [7:0] last;
  integer    err_count = 0, samples_checked = 0, rises = 0, r0, n, m, c;
  ctl_model ctl_model_inst (.clk_i(clk_i), .ck_o(ck_i), .cmd_o(cmd_i), .chop_o(chop_w),
    .nib_o(nib_w));
  ddr3_timing_core ddr3_timing_core_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ck_i(ck_i),
    .cke_i(cke_i), .cmd_i(cmd_i), .on_die_termination_control_i(odt_q),
    .burst_chop_four_i(chop_w), .auto_precharge_i(ap_q), .nibble_select_i(nib_w),
    .write_latency_setting_i(4'h5), .additive_latency_i(4'h0), .read_latency_setting_i(4'h5),
    .chop_fixed_i(chop_fixed_q), .readout_enable_i(readout_q), .write_start_o(write_start_o),
    .term_enable_o(term_enable_o), .busy_o(busy_o), .calibration_busy_o(calibration_busy_o),
    .powerdown_o(powerdown_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .term_short_o(term_short_o),
    .refresh_early_o(refresh_early_o));
  // clocks and memory clock rise count
  always #10 clk_i = ~clk_i;
  always @(posedge ck_i) rises = rises + 1;
  task check(input [31:0] seen, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  end
  endtask
  task do_reset;
  begin
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task t_term;
  begin
    ctl_model_inst.issue(`CMD_MRS, 1'b0, 1'b0, 1'b0);
    r0 = rises;
    ctl_model_inst.level;
    @(posedge clk_i);
    check(rises - r0, `LEVELING_FIRST_STROBE_DELAY);
    ctl_model_inst.issue(`CMD_NOP, 1'b0, 1'b0, 1'b0);
    odt_q <= 1'b1;
    r0 = rises;
    repeat (300) if (term_enable_o !== 1'b1) @(posedge clk_i);
    check(rises - r0, 4);
    $display("term latency done");
  end
  endtask
  task t_write;
  begin
    for (c = 0; c < 2; c = c + 1)
    begin
      chop_fixed_q <= c[0];
      ctl_model_inst.issue(`CMD_WR, 1'b0, 1'b0, 1'b0);
      r0 = rises;
      repeat (400) if (write_start_o !== 1'b1) @(posedge clk_i);
      check(rises - r0, c ? 7 : 9);
    end
    check(term_short_o, 0);
    chop_fixed_q <= 1'b0;
    ctl_model_inst.issue(`CMD_WR, 1'b0, 1'b0, 1'b0);
    odt_q <= 1'b0;
    repeat (80) @(posedge clk_i);
    check(term_short_o, 1);
    do_reset;
    $display("write start done");
  end
  endtask
  task t_refresh;
  begin
    ctl_model_inst.issue(`CMD_REF, 1'b0, 1'b0, 1'b0);
    cke_i <= 1'b0;
    repeat (20) if (busy_o !== 1'b1) @(posedge clk_i);
    n = 0;
    while (busy_o === 1'b1 && n < 40)
    begin
      if (n == 8) check(powerdown_o, 0);
      @(posedge clk_i);
      n = n + 1;
    end
    check(n, 13);
    repeat (2) @(posedge clk_i);
    check(powerdown_o, 1);
    cke_i <= 1'b1;
    repeat (24) @(posedge clk_i);
    check(powerdown_o, 0);
    ctl_model_inst.issue(`CMD_REF, 1'b0, 1'b0, 1'b0);
    check(ctl_model_inst.ref_gap <= `REFRESH_AVERAGE_INTERVAL_NORMAL_NS, 1);
    check(refresh_early_o, 0);
    ctl_model_inst.issue(`CMD_REF, 1'b0, 1'b0, 1'b1);
    repeat (40) @(posedge clk_i);
    check(refresh_early_o, 1);
    do_reset;
    $display("refresh done");
  end
  endtask
  task t_cal;
  begin
    ctl_model_inst.issue(`CMD_SHORT_IMPEDANCE_CALIBRATION, 1'b0, 1'b0, 1'b0);
    r0 = rises;
    repeat (20) if (calibration_busy_o !== 1'b1) @(posedge clk_i);
    repeat (700) if (calibration_busy_o === 1'b1) @(posedge clk_i);
    check(rises - r0, 64);
    $display("calibration done");
  end
  endtask
  task t_row;
  begin
    ap_q <= 1'b1;
    ctl_model_inst.issue(`CMD_WR, 1'b0, 1'b0, 1'b0);
    ap_q <= 1'b0;
    cke_i <= 1'b0;
    repeat (20) if (busy_o !== 1'b1) @(posedge clk_i);
    n = 0;
    while (busy_o === 1'b1 && n < 200)
    begin
      if (n == 40) check(powerdown_o, 0);
      @(posedge clk_i);
      n = n + 1;
    end
    check(n, 88);
    repeat (2) @(posedge clk_i);
    check(powerdown_o, 1);
    cke_i <= 1'b1;
    repeat (24) @(posedge clk_i);
    check(powerdown_o, 0);
    $display("row busy done");
  end
  endtask
  task t_read;
  begin
    readout_q <= 1'b1;
    for (c = 0; c < 2; c = c + 1)
    begin
      ctl_model_inst.issue(`CMD_RD, c[0], c[0], 1'b0);
      repeat (200) if (dq_oe_o !== 1'b1) @(posedge clk_i);
      check(dq_o, 8'h00);
      n = 0;
      m = 0;
      last = dq_o;
      while (dq_oe_o === 1'b1 && n < 60)
      begin
        @(posedge clk_i);
        n = n + 1;
        if (dq_oe_o === 1'b1 && dq_o !== last) m = m + 1;
        last = dq_o;
      end
      check(n, c ? 16 : 32);
      check(m, c ? 3 : 7);
    end
    readout_q <= 1'b0;
    ctl_model_inst.issue(`CMD_RD, 1'b0, 1'b0, 1'b0);
    n = 0;
    repeat (100)
    begin
      @(posedge clk_i);
      if (dq_oe_o !== 1'b0) n = n + 1;
    end
    check(n, 0);
    $display("readout done");
  end
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count = err_count + 1;
    $display("BAD %0t watchdog expired", $time);
    summarize;
  end
  // main sequence
  initial
  begin
    do_reset;
    t_term;
    t_write;
    t_refresh;
    t_cal;
    t_row;
    t_read;
    summarize;
  end
endmodule
